// file: ref_clock_pin_top.sv
// Purpose: Reference clock output: picks a base clock, divides it by a
//          power of two and drives the result onto a port pin.
// Assumes: Primary oscillator arrives as a level well below half of
//          clk_sys_i; sleep and strap inputs come from same-clock logic.
// Notes:   The system-clock base is seen through a toggle flop, so the
//          fastest system-derived output is half of clk_sys_i.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ref_clock_pin_params.svh"

// Notes on behaviour
// - Output works in any oscillator configuration while awake; in Sleep it also needs primary mode or keep-alive.
// - Enable bit 15 set drives divided clock on pin; clear disables it.
// - Four-bit field in bits 11..8 picks one of sixteen ratios.
// - Bit 12 set takes primary oscillator, clear takes current system clock.
// - Bit 13 set lets output run in Sleep; clear stops it.
// - Output runs in Sleep only with bits 13 and 12 both set.
// - Sleep powers primary oscillator down unless primary mode or keep-alive.
// - With bit 12 clear, output follows system clock through clock switches.
module ref_clock_pin_top
  import ref_clock_pin_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o,
  input  wire logic        crystal_in_pin_i,
  input  wire logic        sleep_i,
  input  wire logic        primary_mode_i,
  output var  logic        ref_clock_pin_o,
  output var  logic        ref_clock_pin_oe_o,
  output var  logic        primary_osc_enable_o
);

  import ref_clock_pin_pkg::*;

  ref_clock_pin_state_type s;
  ref_clock_pin_state_type next_s;

  // Last count of a half period (length minus one) in base rising edges for codes 1..15
  function automatic logic [`REF_CLOCK_PIN_CNT_W-1:0] half_count(
    input logic [`REF_CLOCK_PIN_DIV_W-1:0] div
  );
    logic [`REF_CLOCK_PIN_CNT_W:0] one_hot;
    one_hot = {{`REF_CLOCK_PIN_CNT_W{1'b0}}, 1'b1} << (div - 4'h1);
    return `REF_CLOCK_PIN_CNT_W'(one_hot - {{`REF_CLOCK_PIN_CNT_W{1'b0}}, 1'b1});
  endfunction : half_count

  // Decoded bus request and access qualifiers
  logic req;
  logic hit_ctrl;
  logic hit_osc;
  logic wr_take;
  logic rd_take;

  // Clock selection and run decision
  logic base_lvl_next;
  logic base_rise;
  logic run;
  logic [15:0] ctrl_view;
  logic [31:0] osc_view;

  // Bus decode
  assign req      = avs_read_i | avs_write_i;
  assign hit_ctrl = (avs_address_i == `REF_CLOCK_PIN_CTRL_OFS);
  assign hit_osc  = (avs_address_i == `REF_CLOCK_PIN_OSC_OFS);
  // Writes land only at the edge where waitrequest is seen low
  assign wr_take  = avs_write_i & ~s.waitreq;
  // Read data is captured one edge early so it stands with waitrequest low
  assign rd_take  = avs_read_i & s.waitreq;

  // Readback images of both registers
  always_comb
  begin
    ctrl_view = `REF_CLOCK_PIN_CTRL_RST;
    ctrl_view[`REF_CLOCK_PIN_EN_BIT]                = s.ctl_en;
    ctrl_view[`REF_CLOCK_PIN_SLEEP_BIT]             = s.ctl_sleep;
    ctrl_view[`REF_CLOCK_PIN_SRC_BIT]               = s.ctl_src;
    ctrl_view[`REF_CLOCK_PIN_DIV_HI:`REF_CLOCK_PIN_DIV_LO]   = s.ctl_div;
    osc_view = `REF_CLOCK_PIN_RDATA_ZERO;
    osc_view[`REF_CLOCK_PIN_KEEP_BIT]  = s.keep_alive;
    osc_view[`REF_CLOCK_PIN_RUN_BIT]   = s.running;
    osc_view[`REF_CLOCK_PIN_OSCEN_BIT] = s.osc_en;
  end

  // Base clock selection
  always_comb
  begin
    if (s.ctl_src)
    begin
      base_lvl_next = s.osc_s2;
      base_rise     = s.osc_s2 & ~s.osc_prev;
    end
    else
    begin
      base_lvl_next = ~s.sys_tgl;
      base_rise     = ~s.sys_tgl;
    end
  end

  // Run decision; awake the primary oscillator is always powered
  always_comb
  begin
    run = s.ctl_en &
          (~sleep_i | (s.ctl_sleep & s.ctl_src & s.osc_en));
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_s = s;

    // Two-flop synchroniser, then an edge-detect stage behind it
    next_s.osc_s1   = crystal_in_pin_i;
    next_s.osc_s2   = s.osc_s1;
    next_s.osc_prev = s.osc_s2;

    // Stands in for the system clock as seen by flop logic
    next_s.sys_tgl  = ~s.sys_tgl;

    next_s.osc_en  = ~(sleep_i & ~primary_mode_i & ~s.keep_alive);
    next_s.running = run;

    next_s.pin_oe = run;

    // Divider; restarts from zero whenever output stops
    if (!run)
    begin
      next_s.pin = 1'b0;
      next_s.cnt = `REF_CLOCK_PIN_CNT_ZERO;
    end
    else if (s.ctl_div == `REF_CLOCK_PIN_DIV_BYPASS)
    begin
      next_s.pin = base_lvl_next;
      next_s.cnt = `REF_CLOCK_PIN_CNT_ZERO;
    end
    else if (base_rise)
    begin
      if (s.cnt == half_count(s.ctl_div))
      begin
        next_s.cnt = `REF_CLOCK_PIN_CNT_ZERO;
        next_s.pin = ~s.pin;
      end
      else
      begin
        next_s.cnt = s.cnt + {{(`REF_CLOCK_PIN_CNT_W-1){1'b0}}, 1'b1};
      end
    end

    // One wait cycle per access, then waitrequest low for one cycle
    next_s.waitreq = ~(req & s.waitreq);

    // Read data capture; unmapped addresses read as zero
    if (rd_take)
    begin
      if (hit_ctrl)
      begin
        next_s.rdata = {16'h0000, ctrl_view};
      end
      else if (hit_osc)
      begin
        next_s.rdata = osc_view;
      end
      else
      begin
        next_s.rdata = `REF_CLOCK_PIN_RDATA_ZERO;
      end
    end

    // Control register write; low byte holds nothing
    if (wr_take && hit_ctrl && avs_byteenable_i[`REF_CLOCK_PIN_CTRL_LANE])
    begin
      next_s.ctl_en    = avs_writedata_i[`REF_CLOCK_PIN_EN_BIT];
      next_s.ctl_sleep = avs_writedata_i[`REF_CLOCK_PIN_SLEEP_BIT];
      next_s.ctl_src   = avs_writedata_i[`REF_CLOCK_PIN_SRC_BIT];
      next_s.ctl_div   = avs_writedata_i[`REF_CLOCK_PIN_DIV_HI:`REF_CLOCK_PIN_DIV_LO];
      // Restart the divider so a new ratio never yields an overlong phase
      next_s.cnt       = `REF_CLOCK_PIN_CNT_ZERO;
      next_s.pin       = 1'b0;
    end

    // Keep-alive write; status bits in the same word are read-only
    if (wr_take && hit_osc && avs_byteenable_i[`REF_CLOCK_PIN_OSC_LANE])
    begin
      next_s.keep_alive = avs_writedata_i[`REF_CLOCK_PIN_KEEP_BIT];
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // zero reset; waitrequest idles high, oscillator powered
      s         <= '0;
      s.waitreq <= 1'b1;
      s.osc_en  <= 1'b1;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign avs_readdata_o       = s.rdata;
  assign avs_waitrequest_o    = s.waitreq;
  assign ref_clock_pin_o      = s.pin;
  assign ref_clock_pin_oe_o   = s.pin_oe;
  assign primary_osc_enable_o = s.osc_en;

endmodule : ref_clock_pin_top
`default_nettype wire

// file: ref_clock_pin_params.svh
// Purpose: Shared constants of the reference clock output block.
// Assumes: Included by the package and the top module; guard stops repeats.
// Notes:   Offsets are byte addresses on a 32-bit Avalon-MM slave.
`ifndef REF_CLOCK_PIN_PARAMS_SVH
`define REF_CLOCK_PIN_PARAMS_SVH

// Register byte offsets
`define REF_CLOCK_PIN_CTRL_OFS      3'h0
`define REF_CLOCK_PIN_OSC_OFS       3'h4

// Control register field positions
`define REF_CLOCK_PIN_EN_BIT        15
`define REF_CLOCK_PIN_SLEEP_BIT     13
`define REF_CLOCK_PIN_SRC_BIT       12
`define REF_CLOCK_PIN_DIV_HI        11
`define REF_CLOCK_PIN_DIV_LO        8

// Oscillator control and status field positions
`define REF_CLOCK_PIN_KEEP_BIT      0
`define REF_CLOCK_PIN_RUN_BIT       8
`define REF_CLOCK_PIN_OSCEN_BIT     9

// Widths and reset values
`define REF_CLOCK_PIN_DIV_W         4
`define REF_CLOCK_PIN_CNT_W         14
`define REF_CLOCK_PIN_CNT_ZERO      14'h0000
`define REF_CLOCK_PIN_CTRL_RST      16'h0000
`define REF_CLOCK_PIN_RDATA_ZERO    32'h0000_0000
`define REF_CLOCK_PIN_DIV_BYPASS    4'h0
`define REF_CLOCK_PIN_CTRL_LANE     1
`define REF_CLOCK_PIN_OSC_LANE      0

`endif

// file: ref_clock_pin_pkg.sv
// Purpose: Types of the reference clock output block.
// Assumes: ref_clock_pin_params.svh is on the include path.
// Notes:   All state of the top module lives in one packed struct.
`include "ref_clock_pin_params.svh"

package ref_clock_pin_pkg;

  // Whole register state of the block
  typedef struct packed {
    logic                   waitreq;
    logic [31:0]            rdata;
    logic                   ctl_en;
    logic                   ctl_sleep;
    logic                   ctl_src;
    logic [`REF_CLOCK_PIN_DIV_W-1:0] ctl_div;
    logic                   keep_alive;
    logic                   osc_s1;
    logic                   osc_s2;
    logic                   osc_prev;
    logic                   sys_tgl;
    logic [`REF_CLOCK_PIN_CNT_W-1:0] cnt;
    logic                   pin;
    logic                   pin_oe;
    logic                   osc_en;
    logic                   running;
  } ref_clock_pin_state_type;

endpackage : ref_clock_pin_pkg

// file: ref_clock_pin_ext_dev.sv
// Purpose: Crystal source and clocked external part
// Assumes: Crystal stays well below a quarter of clk_sys_i
// Notes:   Counts pin rises only while the pin is driven
`timescale 1ns/100ps
`default_nettype none
module ref_clock_pin_ext_dev (
  input  wire logic        pwr_i,
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  output var  logic        xtal_o,
  output var  logic [15:0] rises_o
);
  // Start quiet
  initial
  begin
    xtal_o  = 1'b0;
    rises_o = 16'h0000;
  end
  always #100 if (pwr_i) xtal_o = !xtal_o;
  // Undriven pin rises are noise, so they are skipped
  always @(posedge pin_i) if (oe_i) rises_o = rises_o + 16'h0001;
endmodule : ref_clock_pin_ext_dev
`default_nettype wire

// file: ref_clock_pin_top_sva.sv
// Purpose: Port checks of the reference clock output
// Assumes: Bound into ref_clock_pin_top
// Notes:   A shadow of the control word is built from bus writes
`timescale 1ns/100ps
`default_nettype none
module ref_clock_pin_chk (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [2:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        sleep_i,
  input wire logic        primary_mode_i,
  input wire logic        ref_clock_pin_o,
  input wire logic        ref_clock_pin_oe_o,
  input wire logic        primary_osc_enable_o
);
  logic       s_en, s_sl, s_src;
  logic [3:0] s_div;
  // Shadow moves at the answer edge, when the design takes the write
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      {s_en, s_sl, s_src, s_div} <= 7'h00;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 3'h0
             && avs_byteenable_i[1])
      {s_en, s_sl, s_src, s_div} <= {avs_writedata_i[15],
                                     avs_writedata_i[13:8]};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_read_back:
    assert property (avs_read_i && !avs_waitrequest_o && avs_address_i ==
      3'h0 |-> avs_readdata_o == {16'h0, s_en, 1'b0, s_sl, s_src, s_div,
      8'h00}) else $error("control readback wrong");
  chk_off_quiet:
    assert property ((!s_en)[*3] |-> !ref_clock_pin_oe_o)
    else $error("pin driven while disabled");
  chk_on_drives:
    assert property ((s_en && !sleep_i && ce_i)[*3] |-> ref_clock_pin_oe_o)
    else $error("pin idle while enabled");
  chk_sleep_stop:
    assert property ((sleep_i && !s_sl)[*3] |-> !ref_clock_pin_oe_o)
    else $error("pin runs in sleep");
  chk_sleep_src:
    assert property ((sleep_i && !s_src)[*3] |-> !ref_clock_pin_oe_o)
    else $error("system source runs in sleep");
  chk_osc_power:
    assert property (!sleep_i || primary_mode_i |=> primary_osc_enable_o)
    else $error("oscillator powered down");
  chk_div_one:
    assert property ($rose(ref_clock_pin_o) && s_div == 4'h1 && !s_src &&
      !sleep_i && !avs_write_i |-> ##2 $fell(ref_clock_pin_o))
    else $error("divide by two period wrong");
  chk_div_zero:
    assert property ($rose(ref_clock_pin_o) && s_div == 4'h0 && !s_src &&
      !sleep_i && !avs_write_i |=> $fell(ref_clock_pin_o))
    else $error("undivided period wrong");
endmodule : ref_clock_pin_chk
bind ref_clock_pin_top ref_clock_pin_chk i_ref_clock_pin_chk (.*);
`default_nettype wire

// file: test_reference_clock_output.sv
// Purpose: Register and pin tests of the reference clock output
// Assumes: Crystal model toggles every 100 ns
// Notes:   Rise counts allow one edge of slack at window ends
`timescale 1ns/100ps
`default_nettype none
module test_reference_clock_output;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic        slp = 1'b0, pm = 1'b1, xtal, wq, pin, oe, pwr;
  logic [2:0]  adr = 3'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] wd = 32'h0, q, rdat;
  logic [15:0] rises, r0, d;
  int          err_count = 0, n_checks = 0, cyc = 0;
  always #12.5 clk = !clk;
  ref_clock_pin_top i_ref_clock_pin_top (.clk_sys_i(clk), .rst_i(rst), .ce_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .crystal_in_pin_i(xtal), .sleep_i(slp),
    .primary_mode_i(pm), .ref_clock_pin_o(pin), .ref_clock_pin_oe_o(oe),
    .primary_osc_enable_o(pwr));
  ref_clock_pin_ext_dev i_ref_clock_pin_ext_dev (.pwr_i(pwr), .pin_i(pin), .oe_i(oe),
    .xtal_o(xtal), .rises_o(rises));
  task stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input [31:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : chk
  // One access; a free edge first so no signal is set twice in a step
  task automatic acc(input logic w, input [2:0] a, input [31:0] dt);
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= dt;
    // Hold the request until waitrequest is sampled low at a rising edge
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    rd  <= 1'b0;
    wr  <= 1'b0;
  endtask : acc
  task settle;
    repeat (4) @(posedge clk);
  endtask : settle
  // Count pin rises over 256 cycles
  task automatic meas(input [15:0] e);
    settle();
    r0 = rises;
    repeat (256) @(posedge clk);
    d = rises - r0;
    chk("pin rises", e, (d + 16'h1 - e <= 16'h2) ? e : d);
  endtask : meas
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 3'h0, 32'h0);
    chk("control", 32'h0, q);
    acc(1'b0, 3'h4, 32'h0);
    chk("osc status", 32'h200, q);
    acc(1'b1, 3'h0, 32'hffff_ffff);
    acc(1'b0, 3'h0, 32'h0);
    chk("control", 32'hbf00, q);
    be <= 4'h1;
    acc(1'b1, 3'h0, 32'h0);
    be <= 4'hf;
    acc(1'b0, 3'h0, 32'h0);
    chk("control", 32'hbf00, q);
    acc(1'b1, 3'h2, 32'hffff);
    acc(1'b0, 3'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int n = 0; n < 4; n++)
    begin
      acc(1'b1, 3'h0, 32'h8000 | (n << 8));
      meas(16'd256 >> (n + 1));
    end
    acc(1'b1, 3'h0, 32'h9100);
    meas(16'd16);
    slp <= 1'b1;
    settle();
    chk("pin enable", 32'h0, oe);
    acc(1'b1, 3'h0, 32'hb100);
    meas(16'd16);
    acc(1'b1, 3'h0, 32'ha100);
    settle();
    chk("pin enable", 32'h0, oe);
    acc(1'b1, 3'h0, 32'hb100);
    pm <= 1'b0;
    settle();
    chk("osc power", 32'h0, pwr);
    chk("pin enable", 32'h0, oe);
    acc(1'b1, 3'h4, 32'h1);
    settle();
    chk("osc power", 32'h1, pwr);
    meas(16'd16);
    slp <= 1'b0;
    acc(1'b1, 3'h0, 32'h0);
    settle();
    chk("pin enable", 32'h0, oe);
    stop_test();
  end
endmodule : test_reference_clock_output
`default_nettype wire
